// [asd_pkg.sv]
`default_nettype none
// ****************************************************************
// Shared constants for the add/subtract datapath.
// ****************************************************************
package asd_pkg;
  // Operation codes presented by the instruction decoder.
  typedef enum logic [2:0]
  {
    ASD_OP_NONE,
    ASD_OP_ADD,
    ASD_OP_ADC,
    ASD_OP_SUB,
    ASD_OP_WORD
  } asd_op_type;

  // Index of each flag in the status vector.
  localparam int ASD_FLAG_C = 0;
  localparam int ASD_FLAG_Z = 1;
  localparam int ASD_FLAG_N = 2;
  localparam int ASD_FLAG_V = 3;
  localparam int ASD_FLAG_S = 4;
  localparam int ASD_FLAG_H = 5;
  localparam int ASD_FLAG_W = 6;

  // Width of the byte datapath and of the immediate constant.
  localparam int ASD_BYTE_W = 8;
  localparam int ASD_IMM_W  = 6;

  // Bit positions used by the flag equations.
  localparam int ASD_MSB    = 7;
  localparam int ASD_HC_BIT = 3;

  // Reset values.
  localparam logic [7:0] ASD_FLAGS_RST = 8'h00;
  localparam logic [7:0] ASD_BYTE_RST  = 8'h00;
endpackage : asd_pkg
`default_nettype wire

// [asd_adder.sv]
`default_nettype none
// ****************************************************************
// Eight-bit adder with carry in, used for every operation.
// ****************************************************************
module asd_adder
  import asd_pkg::*;
(
  input  wire logic [7:0] a,        // First operand.
  input  wire logic [7:0] b,        // Second operand, already inverted for subtract.
  input  wire logic       cin,      // Carry into bit zero.
  output logic      [7:0] sum,      // Eight-bit result.
  output logic            cout,     // Carry out of bit seven.
  output logic            hcout,    // Carry out of bit three.
  output logic            ovf       // Two's complement overflow.
);
  logic [8:0] full;   // Nine-bit sum with carry.
  logic [4:0] low;    // Low nibble sum for the half carry.

  // Combinational sum; the flag terms come from the same carries.
  always_comb
  begin
    full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low   = {1'b0, a[ASD_HC_BIT:0]} + {1'b0, b[ASD_HC_BIT:0]} + {4'h0, cin};
    sum   = full[ASD_MSB:0];
    cout  = full[ASD_BYTE_W];
    hcout = low[ASD_HC_BIT + 1];
    ovf   = (a[ASD_MSB] == b[ASD_MSB]) && (full[ASD_MSB] != a[ASD_MSB]);
  end
endmodule : asd_adder
`default_nettype wire

// [asd_datapath.sv]
`default_nettype none
// ****************************************************************
// Add/subtract datapath of the processor core.
// ****************************************************************
// Operation
// - Add writes dst plus src in one cycle
// - ADC adds carry flag too, one cycle
// - Word immediate add on pair, two cycles
// - SUB writes dst minus src, one cycle
module asd_datapath
  import asd_pkg::*;
(
  input  wire logic       clk,          // Core clock.
  input  wire logic       arst_n,       // Asynchronous reset, active low.
  input  wire asd_op_type op,           // Operation, valid for one cycle.
  input  wire logic [7:0] dst_value,    // Destination or pair low byte.
  input  wire logic [7:0] source_register, // Source register value.
  input  wire logic [7:0] pair_high,    // Pair high byte, word add only.
  input  wire logic [5:0] imm,          // Word add constant.
  output logic            busy,         // High in the second word cycle.
  output logic            wr_low,       // Write result to destination or low.
  output logic            wr_high,      // Write result to pair high byte.
  output logic      [7:0] result,       // Result byte, registered.
  output logic      [7:0] flags         // Status flags, registered.
);
  // ****************************************************************
  // State.
  // ****************************************************************
  typedef enum logic {ASD_IDLE, ASD_HIGH} asd_state_type;

  typedef struct packed
  {
    asd_state_type st;       // Word add phase.
    logic          wlow;     // Low write strobe.
    logic          whigh;    // High write strobe.
    logic [7:0]    res;      // Result byte.
    logic [7:0]    flg;      // Status flags.
    logic [7:0]    hi;       // Held pair high byte.
    logic          cy;       // Carry from low byte.
    logic          zlo;      // Low byte was zero.
  } asd_regs_type;

  asd_regs_type r;           // Registered state.
  asd_regs_type next_r;      // Next state.

  logic [7:0] add_a;         // Adder operand a.
  logic [7:0] add_b;         // Adder operand b.
  logic       add_ci;        // Adder carry in.
  logic [7:0] add_s;         // Adder sum.
  logic       add_co;        // Adder carry out.
  logic       add_hc;        // Adder half carry.
  logic       add_v;         // Adder overflow.

  // ****************************************************************
  // Operand selection.
  // ****************************************************************
  // The high phase reuses the adder with the held byte and the carry.
  always_comb
  begin
    add_a  = dst_value;
    add_b  = source_register;
    add_ci = 1'b0;
    if (r.st == ASD_HIGH)
    begin
      add_a  = r.hi;
      add_b  = ASD_BYTE_RST;
      add_ci = r.cy;
    end
    else
    begin
      case (op)
        ASD_OP_ADC: add_ci = r.flg[ASD_FLAG_C];
        ASD_OP_SUB:
        begin
          add_b  = ~source_register;
          add_ci = 1'b1;
        end
        ASD_OP_WORD: add_b = {2'b00, imm};
        default: add_ci = 1'b0;
      endcase
    end
  end

  asd_adder u_adder
  (
    .a     (add_a),
    .b     (add_b),
    .cin   (add_ci),
    .sum   (add_s),
    .cout  (add_co),
    .hcout (add_hc),
    .ovf   (add_v)
  );

  // ****************************************************************
  // Decoding shared by the flag equations.
  // ****************************************************************
  // True when a result byte is all zeros.
  function automatic logic byte_is_zero(input logic [7:0] value);
    return (value == ASD_BYTE_RST);
  endfunction : byte_is_zero

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // Byte operations finish now; the word add stores the low byte first.
  always_comb
  begin
    next_r       = r;
    next_r.wlow  = 1'b0;
    next_r.whigh = 1'b0;
    if (r.st == ASD_HIGH)
    begin
      // Second word cycle: high byte and the word flags.
      next_r.st                = ASD_IDLE;
      next_r.whigh             = 1'b1;
      next_r.res               = add_s;
      next_r.flg[ASD_FLAG_C]   = ~r.hi[ASD_MSB] & add_s[ASD_MSB] ? 1'b0 :
                                 (r.hi[ASD_MSB] & ~add_s[ASD_MSB]);
      next_r.flg[ASD_FLAG_Z]   = r.zlo & byte_is_zero(add_s);
      next_r.flg[ASD_FLAG_N]   = add_s[ASD_MSB];
      next_r.flg[ASD_FLAG_V]   = ~r.hi[ASD_MSB] & add_s[ASD_MSB];
      next_r.flg[ASD_FLAG_S]   = add_s[ASD_MSB] ^ (~r.hi[ASD_MSB] & add_s[ASD_MSB]);
    end
    else
    begin
      case (op)
        ASD_OP_ADD, ASD_OP_ADC, ASD_OP_SUB:
        begin
          // Subtract reports a borrow, the inverse of the adder carries.
          next_r.wlow             = 1'b1;
          next_r.res              = add_s;
          next_r.flg[ASD_FLAG_C]  = (op == ASD_OP_SUB) ? ~add_co : add_co;
          next_r.flg[ASD_FLAG_H]  = (op == ASD_OP_SUB) ? ~add_hc : add_hc;
          next_r.flg[ASD_FLAG_Z]  = byte_is_zero(add_s);
          next_r.flg[ASD_FLAG_N]  = add_s[ASD_MSB];
          next_r.flg[ASD_FLAG_V]  = add_v;
          next_r.flg[ASD_FLAG_S]  = add_s[ASD_MSB] ^ add_v;
        end
        ASD_OP_WORD:
        begin
          // First word cycle: low byte written, carry held.
          next_r.st   = ASD_HIGH;
          next_r.wlow = 1'b1;
          next_r.res  = add_s;
          next_r.hi   = pair_high;
          next_r.cy   = add_co;
          next_r.zlo  = byte_is_zero(add_s);
        end
        default: next_r.st = ASD_IDLE;
      endcase
    end
  end

  // Register stage.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '{st: ASD_IDLE, wlow: 1'b0, whigh: 1'b0, res: ASD_BYTE_RST,
             flg: ASD_FLAGS_RST, hi: ASD_BYTE_RST, cy: 1'b0, zlo: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign busy    = (r.st == ASD_HIGH);
  assign wr_low  = r.wlow;
  assign wr_high = r.whigh;
  assign result  = r.res;
  assign flags   = r.flg;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // A plain add writes the eight-bit sum one cycle after it is taken.
  a_add_result: assert property (@(posedge clk) disable iff (!arst_n)
    (op == ASD_OP_ADD && !busy) |=>
      wr_low && result == $past(8'(dst_value + source_register)))
    else $error("add result wrong");
  // The add reports a carry when the nine-bit sum leaves the byte.
  a_add_carry: assert property (@(posedge clk) disable iff (!arst_n)
    (op == ASD_OP_ADD && !busy) |=>
      flags[ASD_FLAG_C] == $past((9'(dst_value) + 9'(source_register)) > 9'h0ff))
    else $error("add carry wrong");
  // Add with carry folds in the carry flag that stood when it was taken.
  a_adc_result: assert property (@(posedge clk) disable iff (!arst_n)
    (op == ASD_OP_ADC && !busy) |=>
      result == $past(8'(dst_value + source_register + {7'h00, flags[ASD_FLAG_C]})))
    else $error("adc result wrong");
  // Subtract writes the difference and reports a borrow as the carry.
  a_sub_result: assert property (@(posedge clk) disable iff (!arst_n)
    (op == ASD_OP_SUB && !busy) |=>
      wr_low && result == $past(8'(dst_value - source_register))
      && flags[ASD_FLAG_C] == $past(dst_value < source_register))
    else $error("sub result wrong");
  // The word add writes the low byte first and the high byte one cycle later.
  a_word_two: assert property (@(posedge clk) disable iff (!arst_n)
    (op == ASD_OP_WORD && !busy) |=> wr_low && !wr_high ##1 wr_high && !wr_low)
    else $error("word add not two cycles");
  // Both written bytes together make the sixteen-bit sum of pair and constant.
  a_word_sum: assert property (@(posedge clk) disable iff (!arst_n)
    (op == ASD_OP_WORD && !busy) |-> ##2
      {result, $past(result)} == $past({pair_high, dst_value} + {10'h000, imm}, 2))
    else $error("word add sum wrong");
  // The word carry and overflow follow the sign of the pair before and after.
  a_word_flags: assert property (@(posedge clk) disable iff (!arst_n)
    (op == ASD_OP_WORD && !busy) |-> ##2
      flags[ASD_FLAG_C] == ($past(pair_high[ASD_MSB], 2) && !result[ASD_MSB])
      && flags[ASD_FLAG_V] == (!$past(pair_high[ASD_MSB], 2) && result[ASD_MSB]))
    else $error("word add flags wrong");
  // Busy lasts a single cycle, and no write starts while it is high.
  a_busy_one: assert property (@(posedge clk) disable iff (!arst_n)
    busy |=> !busy && !wr_low)
    else $error("busy held or write taken while busy");
  // Every byte operation leaves the zero flag in step with its result.
  a_zero_flag: assert property (@(posedge clk) disable iff (!arst_n)
    wr_low && !busy |-> flags[ASD_FLAG_Z] == (result == ASD_BYTE_RST))
    else $error("zero flag wrong");
endmodule : asd_datapath
`default_nettype wire

// [asd_wb_model.sv]
`default_nettype none
// ****************************************************************
// Write-back side: the register pair that takes the result pulses.
// ****************************************************************
module asd_wb_model
(
  input  wire logic        clk,     // Core clock.
  input  wire logic        arst_n,  // Reset, active low.
  input  wire logic        wr_low,  // Destination or low byte write.
  input  wire logic        wr_high, // Pair high byte write.
  input  wire logic [7:0]  result,  // Byte being written.
  output logic      [15:0] pair     // Register pair as stored.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each pulse lands in its own half, so a missed or late pulse shows.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pair <= 16'h0000;
    else
    begin
      if (wr_low)
        pair[7:0] <= result;
      if (wr_high)
        pair[15:8] <= result;
    end
  end
endmodule : asd_wb_model
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top
  import asd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, arst_n, busy, wr_low, wr_high;
  asd_op_type op;
  logic [7:0] dst_value, source_register, pair_high, result, flags;
  logic [5:0] imm;
  logic [5:0] ef;   // Expected flags H,S,V,N,Z,C.
  logic [15:0] pair; // Pair as the write-back side holds it.
  int errors, compares;
  asd_datapath u_asd_datapath (.clk(clk), .arst_n(arst_n), .op(op), .dst_value(dst_value),
    .source_register(source_register), .pair_high(pair_high), .imm(imm), .busy(busy),
    .wr_low(wr_low), .wr_high(wr_high), .result(result), .flags(flags));
  asd_wb_model u_asd_wb_model (.clk(clk), .arst_n(arst_n), .wr_low(wr_low),
    .wr_high(wr_high), .result(result), .pair(pair));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // One byte operation; result and flags are worked out before it is issued.
  task automatic byte_op(input asd_op_type o, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    logic [4:0] hc;
    logic       sb, ci, v;
    sb = (o == ASD_OP_SUB);
    ci = (o == ASD_OP_ADC) ? ef[ASD_FLAG_C] : 1'b0;
    r  = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b} + 9'(ci);
    hc = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
    v  = ((a[7] ^ b[7]) == sb) && (r[7] != a[7]);
    ef = {hc[4], r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]};
    op = o;
    dst_value = a;
    source_register = b;
    @(posedge clk);
    #1;
    check({busy, wr_low, wr_high}, 3'b010);
    check(result, r[7:0]);
    check(flags[5:0], ef);
  endtask : byte_op
  // Word add; an add offered while busy must be ignored.
  task automatic word_op(input logic [15:0] p, input logic [5:0] k);
    logic [16:0] r;
    logic        v;
    r = {1'b0, p} + {11'h000, k};
    v = !p[15] && r[15];
    op = ASD_OP_WORD;
    dst_value = p[7:0];
    pair_high = p[15:8];
    imm = k;
    @(posedge clk);
    #1;
    check({busy, wr_low, wr_high}, 3'b110);
    check(result, r[7:0]);
    op = ASD_OP_ADD;
    @(posedge clk);
    #1;
    check({busy, wr_low, wr_high}, 3'b001);
    check(result, r[15:8]);
    ef = {ef[5], r[15] ^ v, v, r[15], r[15:0] == 16'h0000, r[16]};
    check(flags[5:0], ef);
    op = ASD_OP_NONE;
    @(posedge clk);
    #1;
    check(pair, r[15:0]);
  endtask : word_op
  task automatic t_add;
    byte_op(ASD_OP_ADD, 8'h0f, 8'h01);
    byte_op(ASD_OP_ADD, 8'h7f, 8'h01);
    byte_op(ASD_OP_ADD, 8'hff, 8'h01);
  endtask : t_add
  task automatic t_adc;
    byte_op(ASD_OP_ADC, 8'h10, 8'h20);
    byte_op(ASD_OP_ADC, 8'h80, 8'h80);
    byte_op(ASD_OP_ADC, 8'hff, 8'h00);
  endtask : t_adc
  task automatic t_sub;
    byte_op(ASD_OP_SUB, 8'h05, 8'h05);
    byte_op(ASD_OP_SUB, 8'h00, 8'h01);
    byte_op(ASD_OP_SUB, 8'h80, 8'h01);
  endtask : t_sub
  task automatic t_word;
    word_op(16'h00ff, 6'h3f);
    word_op(16'hffff, 6'h01);
    word_op(16'h7fff, 6'h01);
  endtask : t_word
  // Cuts a hang short well past the roughly two dozen cycles the tests need.
  initial
  begin
    #20000;
    errors++;
    print_verdict();
  end
  initial
  begin
    {arst_n, dst_value, source_register, pair_high, imm, ef} = '0;
    op = ASD_OP_NONE;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    check({busy, wr_low, wr_high, result}, 11'h000);
    check(flags, 8'h00);
    t_add();
    t_adc();
    t_sub();
    t_word();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
